// ---- bench/cfr_forward_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfr_forward_config_regs_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic hclk, hresetn, hsel, hwrite, frame_start, frame_end;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] v;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, internal_osc_select, ref_clock_half;
  wire logic [15:0] frame_number;
  wire logic [1:0] tx_lane_rate;
  wire logic [3:0] rx_forward_off, rx_output_select;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Forwarding patterns: block, enable, block, remap, then enable two ports
  logic [7:0] v_tab [5] = '{8'hf5, 8'h05, 8'hf5, 8'hfa, 8'h3a};

  // Single slave, so its ready is the bus ready
  cfr_forward_config_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start),
    .frame_end(frame_end), .frame_number(frame_number),
    .internal_osc_select(internal_osc_select), .ref_clock_half(ref_clock_half),
    .tx_lane_rate(tx_lane_rate), .rx_forward_off(rx_forward_off),
    .rx_output_select(rx_output_select));

  // 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Hang guard, far beyond the several hundred cycles the tests need
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------
  // AHB-Lite single transfers; write and read helpers use word size
  // ----------------------------------------
  // Address phase held until ready, then data phase held until ready again
  task automatic ahb_xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                          input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= cfr_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic ahb_write(input logic [9:0] a, input logic [7:0] d);
    ahb_xfer(1'b1, a, {24'hffffff, d}, 3'h2);
  endtask

  task automatic ahb_read(input logic [9:0] a, input logic [31:0] exp, input string name);
    ahb_xfer(1'b0, a, 32'h0, 3'h2);
    check(name, rd, exp);
  endtask

  // One Frame Start pulse; number is settled one edge later
  task automatic frame_step(input logic [15:0] exp);
    @(posedge hclk);
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    #1;
    check("frame_number", {16'h0, frame_number}, {16'h0, exp});
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, frame_start, frame_end, htrans, hsize} = '0;
    haddr = '0;
    hwdata = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of the writable registers and the control and frame outputs
    ahb_read(cfr_pkg::ADDR_FRAME_LIMIT_LOW, 32'h04, "limit_low");
    ahb_read(cfr_pkg::ADDR_FRAME_LIMIT_HIGH, 32'h00, "limit_high");
    ahb_read(cfr_pkg::ADDR_TX_PLL_CONTROL, 32'h02, "pll");
    ahb_read(cfr_pkg::ADDR_FORWARD_CONTROL_ONE, 32'hf0, "fwd");
    ahb_read(10'h084, 32'h0, "unmapped");
    check("rate", {30'h0, tx_lane_rate}, 32'h2);
    check("fwd_off", {28'h0, rx_forward_off}, 32'hf);
    check("osc", {31'h0, internal_osc_select}, 32'h0);
    check("half", {31'h0, ref_clock_half}, 32'h0);
    check("out_sel", {28'h0, rx_output_select}, 32'h0);
    check("frame_number", {16'h0, frame_number}, 32'h0);
    $display("test reset done");
    // Every lane rate; 100 MHz never paired with 400 Mbps, reserved bits written ones
    for (int r = 0; r < 4; r++) begin
      v = {4'h0, r[0], logic'(r != 3), r[1:0]};
      ahb_write(cfr_pkg::ADDR_TX_PLL_CONTROL, {4'hf, v[3:0]});
      ahb_read(cfr_pkg::ADDR_TX_PLL_CONTROL, {24'h0, v}, "pll");
      check("osc", {31'h0, internal_osc_select}, {31'h0, v[3]});
      check("half", {31'h0, ref_clock_half}, {31'h0, v[2]});
      check("rate", {30'h0, tx_lane_rate}, {30'h0, v[1:0]});
    end
    $display("test pll done");
    // Remap only while the port is blocked
    foreach (v_tab[i]) begin
      ahb_write(cfr_pkg::ADDR_FORWARD_CONTROL_ONE, v_tab[i]);
      ahb_read(cfr_pkg::ADDR_FORWARD_CONTROL_ONE, {24'h0, v_tab[i]}, "fwd");
      check("fwd_off", {28'h0, rx_forward_off}, {28'h0, v_tab[i][7:4]});
      check("out_sel", {28'h0, rx_output_select}, {28'h0, v_tab[i][3:0]});
    end
    $display("test forward done");
    // Default limit 4: count and wrap, frame end has no effect
    for (int i = 1; i <= 4; i++) frame_step(16'(i));
    frame_end <= 1'b1;
    frame_step(16'h1);
    frame_end <= 1'b0;
    frame_step(16'h2);
    frame_step(16'h3);
    ahb_read(cfr_pkg::ADDR_FRAME_STATUS, 32'h3, "status");
    // Narrow write is ignored, then lower the limit mid count
    ahb_xfer(1'b1, cfr_pkg::ADDR_FRAME_LIMIT_LOW, 32'h0, 3'h0);
    ahb_read(cfr_pkg::ADDR_FRAME_LIMIT_LOW, 32'h04, "limit_low");
    ahb_write(cfr_pkg::ADDR_FRAME_LIMIT_LOW, 8'h02);
    check("frame_number", {16'h0, frame_number}, 32'h3);
    frame_step(16'h1);
    frame_step(16'h2);
    // Zero limit disables numbering
    ahb_write(cfr_pkg::ADDR_FRAME_LIMIT_LOW, 8'h00);
    frame_step(16'h0);
    frame_step(16'h0);
    // High byte joins the limit: 0x0102 counts past 255
    ahb_write(cfr_pkg::ADDR_FRAME_LIMIT_HIGH, 8'h01);
    ahb_write(cfr_pkg::ADDR_FRAME_LIMIT_LOW, 8'h02);
    ahb_read(cfr_pkg::ADDR_FRAME_LIMIT_HIGH, 32'h01, "limit_high");
    for (int i = 1; i <= 258; i++) frame_step(16'(i));
    frame_step(16'h1);
    $display("test frame numbering done");
    stop_test();
  end
endmodule

`default_nettype wire

// ---- hdl/cfr_forward_config_regs.sv ----
// Summary of operation
// - Frame start and end carry 16-bit number
// - Zero limit gives frame number zero
// - Nonzero limit counts 1 to limit, wraps
// - Limit low byte bits 7:0, reset 0x04
// - Limit high byte separate, reset zero
// - Oscillator select: 0 external, 1 internal
// - Reference mode: 0 200 MHz, 1 100 MHz
// - Two-bit lane rate, reset 10
// - Per-port forwarding off bits, reset ones
// - Per-port output select bits, reset zeros
// - PLL control bits 7:4 reserved, read zero
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module cfr_forward_config_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Frame generator events
  input wire logic frame_start,
  input wire logic frame_end,
  output logic [15:0] frame_number,
  // Clock and rate controls
  output logic internal_osc_select,
  output logic ref_clock_half,
  output logic [1:0] tx_lane_rate,
  // Forwarding controls
  output logic [3:0] rx_forward_off,
  output logic [3:0] rx_output_select
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend;
  logic [9:0] wr_addr;
  logic rd_req;
  logic [9:0] rd_addr;
  logic [7:0] frame_limit_low_byte;
  logic [7:0] frame_limit_high_byte;
  logic [15:0] active_limit;
  logic [31:0] next_rdata;

  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign rd_addr = haddr[9:0];

  // Single-cycle slave, never stalls or errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Latch write address; data arrives a cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite && (hsize == 3'h2) && (haddr[11:10] == 2'h0)
        && (haddr[31:12] == 20'h00000);
      wr_addr <= haddr[9:0];
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Frame limit bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_limit_low_byte <= cfr_pkg::RST_FRAME_LIMIT_LOW;
      frame_limit_high_byte <= cfr_pkg::RST_FRAME_LIMIT_HIGH;
    end else if (wr_pend) begin
      if (wr_addr == cfr_pkg::ADDR_FRAME_LIMIT_LOW) begin
        frame_limit_low_byte <= hwdata[7:0];
      end
      if (wr_addr == cfr_pkg::ADDR_FRAME_LIMIT_HIGH) begin
        frame_limit_high_byte <= hwdata[7:0];
      end
    end
  end

  // Clock source and lane rate; bits 7:4 are not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_osc_select <= cfr_pkg::RST_INTERNAL_OSC_SELECT;
      ref_clock_half <= cfr_pkg::RST_REF_CLOCK_HALF;
      tx_lane_rate <= cfr_pkg::RST_TX_LANE_RATE;
    end else if (wr_pend && wr_addr == cfr_pkg::ADDR_TX_PLL_CONTROL) begin
      internal_osc_select <= hwdata[cfr_pkg::POS_INTERNAL_OSC_SELECT];
      ref_clock_half <= hwdata[cfr_pkg::POS_REF_CLOCK_HALF];
      tx_lane_rate <= hwdata[cfr_pkg::POS_TX_LANE_RATE +: 2];
    end
  end

  // Forwarding off and output mapping; no ordering enforced by hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_forward_off <= cfr_pkg::RST_FORWARD_OFF;
      rx_output_select <= cfr_pkg::RST_OUTPUT_SELECT;
    end else if (wr_pend && wr_addr == cfr_pkg::ADDR_FORWARD_CONTROL_ONE) begin
      rx_forward_off <= hwdata[cfr_pkg::POS_FORWARD_OFF +: 4];
      rx_output_select <= hwdata[cfr_pkg::POS_OUTPUT_SELECT +: 4];
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Reserved and unmapped locations read zero
  always_comb begin
    next_rdata = 32'h00000000;
    case (rd_addr)
      cfr_pkg::ADDR_FRAME_LIMIT_HIGH: next_rdata[7:0] = frame_limit_high_byte;
      cfr_pkg::ADDR_FRAME_LIMIT_LOW: next_rdata[7:0] = frame_limit_low_byte;
      cfr_pkg::ADDR_TX_PLL_CONTROL: next_rdata[3:0] = {internal_osc_select,
        ref_clock_half, tx_lane_rate};
      cfr_pkg::ADDR_FORWARD_CONTROL_ONE: next_rdata[7:0] = {rx_forward_off, rx_output_select};
      cfr_pkg::ADDR_FRAME_STATUS: next_rdata[15:0] = frame_number;
      default: next_rdata = 32'h00000000;
    endcase
    if (haddr[31:10] != 22'h000000) begin
      next_rdata = 32'h00000000;
    end
  end

  // Read data registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_req) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Frame number generator
  // ----------------------------------------
  // Limit is sampled at frame start so start and end of a frame agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_limit <= {cfr_pkg::RST_FRAME_LIMIT_HIGH, cfr_pkg::RST_FRAME_LIMIT_LOW};
      frame_number <= cfr_pkg::FRAME_NUMBER_IDLE;
    end else if (frame_start) begin
      active_limit <= {frame_limit_high_byte, frame_limit_low_byte};
      if ({frame_limit_high_byte, frame_limit_low_byte} == 16'h0000) begin
        frame_number <= cfr_pkg::FRAME_NUMBER_IDLE;
      end else if (frame_number == 16'h0000 ||
          frame_number >= {frame_limit_high_byte, frame_limit_low_byte}) begin
        frame_number <= cfr_pkg::FRAME_NUMBER_FIRST;
      end else begin
        frame_number <= frame_number + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_zero_limit;
    @(posedge hclk) disable iff (!hresetn)
    frame_start && {frame_limit_high_byte, frame_limit_low_byte} == 16'h0000
      |=> frame_number == 16'h0000;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit gave nonzero number");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    frame_start && {frame_limit_high_byte, frame_limit_low_byte} != 16'h0000
      && frame_number >= {frame_limit_high_byte, frame_limit_low_byte}
      |=> frame_number == 16'h0001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame number did not wrap to one");

  property p_count;
    @(posedge hclk) disable iff (!hresetn)
    frame_start && frame_number != 16'h0000
      && frame_number < {frame_limit_high_byte, frame_limit_low_byte}
      |=> frame_number == $past(frame_number) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("frame number did not advance");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    !frame_start |=> $stable(frame_number) && $stable(active_limit);
  endproperty
  a_hold: assert property (p_hold) else $error("frame number moved mid frame");

  property p_pll_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == cfr_pkg::ADDR_TX_PLL_CONTROL
      |=> {internal_osc_select, ref_clock_half, tx_lane_rate} == $past(hwdata[3:0]);
  endproperty
  a_pll_write: assert property (p_pll_write) else $error("pll control not written");

  property p_reserved_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_req && rd_addr == cfr_pkg::ADDR_TX_PLL_CONTROL |=> hrdata[31:4] == 28'h0000000;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits nonzero");

  property p_fwd_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == cfr_pkg::ADDR_FORWARD_CONTROL_ONE
      |=> rx_forward_off == $past(hwdata[7:4]) && rx_output_select == $past(hwdata[3:0]);
  endproperty
  a_fwd_write: assert property (p_fwd_write) else $error("forward control not written");

  property p_limit_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_req && rd_addr == cfr_pkg::ADDR_FRAME_LIMIT_LOW && haddr[31:10] == 22'h000000
      |=> hrdata == {24'h000000, $past(frame_limit_low_byte)};
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("limit low read wrong");

  property p_high_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == cfr_pkg::ADDR_FRAME_LIMIT_HIGH
      |=> frame_limit_high_byte == $past(hwdata[7:0]);
  endproperty
  a_high_write: assert property (p_high_write) else $error("limit high not written");

  property p_map_stable;
    @(posedge hclk) disable iff (!hresetn)
    !wr_pend |=> $stable(rx_output_select) && $stable(tx_lane_rate);
  endproperty
  a_map_stable: assert property (p_map_stable) else $error("control changed without write");

  property p_low_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == cfr_pkg::ADDR_FRAME_LIMIT_LOW
      |=> frame_limit_low_byte == $past(hwdata[7:0]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("limit low not written");

  // The count and wrap checks skip the step out of zero, so guard it here
  property p_first_number;
    @(posedge hclk) disable iff (!hresetn)
    frame_start && frame_number == 16'h0000
      && {frame_limit_high_byte, frame_limit_low_byte} != 16'h0000
      |=> frame_number == 16'h0001;
  endproperty
  a_first_number: assert property (p_first_number) else $error("numbering did not start at one");

  property p_limit_sample;
    @(posedge hclk) disable iff (!hresetn)
    frame_start |=> active_limit == {$past(frame_limit_high_byte), $past(frame_limit_low_byte)};
  endproperty
  a_limit_sample: assert property (p_limit_sample) else $error("limit not taken at frame start");

  property p_pll_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_req && rd_addr == cfr_pkg::ADDR_TX_PLL_CONTROL && haddr[31:10] == 22'h000000
      |=> hrdata[3:0] == {$past(internal_osc_select), $past(ref_clock_half),
        $past(tx_lane_rate)};
  endproperty
  a_pll_read: assert property (p_pll_read) else $error("pll control read wrong");

  property p_fwd_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_req && rd_addr == cfr_pkg::ADDR_FORWARD_CONTROL_ONE && haddr[31:10] == 22'h000000
      |=> hrdata == {24'h000000, $past(rx_forward_off), $past(rx_output_select)};
  endproperty
  a_fwd_read: assert property (p_fwd_read) else $error("forward control read wrong");

  property p_status_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_req && rd_addr == cfr_pkg::ADDR_FRAME_STATUS && haddr[31:10] == 22'h000000
      |=> hrdata == {16'h0000, $past(frame_number)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("frame status read wrong");

  property p_ctrl_stable;
    @(posedge hclk) disable iff (!hresetn)
    !wr_pend |=> $stable(internal_osc_select) && $stable(ref_clock_half)
      && $stable(rx_forward_off) && $stable(frame_limit_low_byte);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("setting changed without write");

  // Main scenarios
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    frame_start && frame_number == active_limit && active_limit != 16'h0000);
  c_zero: cover property (@(posedge hclk) disable iff (!hresetn)
    frame_start && active_limit == 16'h0000);
  c_fwd_on: cover property (@(posedge hclk) disable iff (!hresetn) rx_forward_off == 4'h0);
  c_slow_rate: cover property (@(posedge hclk) disable iff (!hresetn)
    tx_lane_rate == cfr_pkg::RATE_400M);

  // frame_end only marks the end packet; number already stands
  logic unused_ok;
  assign unused_ok = frame_end ^ (|hwdata[31:8]) ^ (|htrans[0]);

endmodule
`default_nettype wire

// ---- hdl/cfr_pkg.sv ----
package cfr_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] IDX_FRAME_LIMIT_HIGH = 8'h1d;
  localparam logic [7:0] IDX_FRAME_LIMIT_LOW = 8'h1e;
  localparam logic [7:0] IDX_TX_PLL_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_FORWARD_CONTROL_ONE = 8'h20;
  localparam logic [9:0] ADDR_FRAME_LIMIT_HIGH = {IDX_FRAME_LIMIT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_FRAME_LIMIT_LOW = {IDX_FRAME_LIMIT_LOW, 2'b00};
  localparam logic [9:0] ADDR_TX_PLL_CONTROL = {IDX_TX_PLL_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_FORWARD_CONTROL_ONE = {IDX_FORWARD_CONTROL_ONE, 2'b00};
  localparam logic [9:0] ADDR_FRAME_STATUS = 10'h090;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_FRAME_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] RST_FRAME_LIMIT_LOW = 8'h04;
  localparam logic [0:0] RST_INTERNAL_OSC_SELECT = 1'h0;
  localparam logic [0:0] RST_REF_CLOCK_HALF = 1'h0;
  localparam logic [1:0] RST_TX_LANE_RATE = 2'h2;
  localparam logic [3:0] RST_FORWARD_OFF = 4'hf;
  localparam logic [3:0] RST_OUTPUT_SELECT = 4'h0;
  localparam logic [15:0] FRAME_NUMBER_IDLE = 16'h0000;
  localparam logic [15:0] FRAME_NUMBER_FIRST = 16'h0001;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_INTERNAL_OSC_SELECT = 3;
  localparam int POS_REF_CLOCK_HALF = 2;
  localparam int POS_TX_LANE_RATE = 0;
  localparam int POS_FORWARD_OFF = 4;
  localparam int POS_OUTPUT_SELECT = 0;

  // ----------------------------------------
  // Lane rate codes
  // ----------------------------------------
  localparam logic [1:0] RATE_1G5 = 2'h0;
  localparam logic [1:0] RATE_1G2 = 2'h1;
  localparam logic [1:0] RATE_800M = 2'h2;
  localparam logic [1:0] RATE_400M = 2'h3;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage
